// file: common/event_sampler_map.svh
`ifndef EVENT_SAMPLER_MAP_SVH
`define EVENT_SAMPLER_MAP_SVH

// Event codes in record byte 0
`define CODE_BRANCH 8'h03
`define CODE_MISS 8'h04

// Bit positions inside record byte 3
`define FLAG_MERGED 4
`define FLAG_PRED_VALID 5
`define FLAG_PRED_CORRECT 6
`define FLAG_TAKEN 7
`define FLAG_ADDR_VALID 4
`define FLAG_SRC_LSB 5

// Record geometry
`define RECORD_BITS 256
`define RECORD_DEPTH 8

// Latency measurement
`define LAT_ROUND_LOG2 4
`define LAT_CAP_LOG2 10
`define LAT_UNIT_BITS 6
`define LAT_UNIT_MAX 6'h3f
`define PRESCALE_LAST 4'hf
`define MISS_SLOTS 4

// Reset values
`define COUNTER_RESET 32'h00000000

`endif

// file: common/event_sampler_pkg.sv
package event_sampler_pkg;
  typedef logic [255:0] record_type;
  typedef logic [1:0] slot_type;
  typedef logic [5:0] units_type;
  typedef logic [63:0] addr_type;
  typedef enum {
    SEL_NONE,
    SEL_BRANCH,
    SEL_MISS
  } source_sel_type;
endpackage

// file: design/record_fifo.sv
`timescale 1ns/100ps
module record_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] fill;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  assign inReady = (fill != DEPTH[PW:0]);
  assign outValid = (fill != '0);
  assign outData = store[rdPtr];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      fill <= fill + {{PW{1'b0}}, doWrite} - {{PW{1'b0}}, doRead};
    end
  end

  // Data array needs no reset; valid comes from fill
  always_ff @(posedge clock) begin
    if (doWrite) begin
      store[wrPtr] <= inData;
    end
  end
endmodule

// file: design/miss_latency_tracker.sv
`timescale 1ns/100ps
`include "event_sampler_map.svh"
module miss_latency_tracker
  import event_sampler_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic startValid,
  input wire slot_type startSlot,
  input wire logic startSecond,
  input wire addr_type startAddr,
  input wire addr_type startPc,
  input wire logic doneValid,
  input wire slot_type doneSlot,
  output logic doneActive,
  output logic [31:0] doneLatency,
  output addr_type doneAddr,
  output addr_type donePc
);
  logic active [`MISS_SLOTS];
  units_type units [`MISS_SLOTS];
  addr_type addr [`MISS_SLOTS];
  addr_type pc [`MISS_SLOTS];
  logic [3:0] prescale;
  // One shared prescaler: first step lands anywhere in the first 16 cycles
  wire tick = (prescale == `PRESCALE_LAST);

  assign doneActive = active[doneSlot];
  assign doneLatency = {22'h0, units[doneSlot], 4'h0};
  assign doneAddr = addr[doneSlot];
  assign donePc = pc[doneSlot];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prescale <= 4'h0;
      for (int i = 0; i < `MISS_SLOTS; i++) begin
        active[i] <= 1'b0;
        units[i] <= '0;
        addr[i] <= '0;
        pc[i] <= '0;
      end
    end else begin
      prescale <= prescale + 4'h1;
      for (int i = 0; i < `MISS_SLOTS; i++) begin
        if (active[i] && tick && units[i] != `LAT_UNIT_MAX) begin
          units[i] <= units[i] + 6'h01;
        end
        if (doneValid && doneSlot == slot_type'(i)) begin
          active[i] <= 1'b0;
        end
        if (startValid && startSlot == slot_type'(i)) begin
          if (startSecond && active[i]) begin
            // Second half of a split load keeps one slot, lower address
            if (startAddr < addr[i]) begin
              addr[i] <= startAddr;
            end
          end else begin
            active[i] <= 1'b1;
            units[i] <= '0;
            addr[i] <= startAddr;
            pc[i] <= startPc;
          end
        end
      end
    end
  end
endmodule

// file: design/branch_and_cache_miss_event_sampler.sv
// Operation
// - Each retired control transfer decrements the branch counter; negative emits a record.
// - Branch record byte 0 holds event code three.
// - Byte 1 of each record holds the eight-bit core tag.
// - Byte 3 bit 4 marks a branch merged with a flag-setting op.
// - Byte 3 bit 5 set only when prediction outcome was captured.
// - Byte 3 bit 6 is one when prediction correct, zero otherwise.
// - Unconditional branch with valid prediction always reports correct.
// - Byte 3 bit 7 is taken; always one for unconditional branches.
// - Bytes 23..16 hold next executed address: target or fall-through.
// - Next address is the effective address, without segment base.
// - Bytes 31..24 hold cycle stamp when enabled, else zero.
// - Eligible load misses by latency threshold and/or selected source decrement miss counter.
// - Miss counter going negative stores a record with code four.
// - A split load missing twice counts once, reports lower address.
// - Only misses from the instruction's own loads are counted.
// - Misses from the profiler's own accesses are never counted.
// - Latency rounds to multiples of sixteen, counting sixteen per sixteen cycles.
// - First sixteen-step may land anywhere in the first sixteen cycles.
// - Latency counter saturates at 1008 and stops.
// - Threshold is a multiple of sixteen, compared against measured latency.
// - Miss record bytes 7..4 hold total latency in cycles.
`timescale 1ns/100ps
`include "event_sampler_map.svh"
module branch_and_cache_miss_event_sampler
  import event_sampler_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] coreTag,
  input wire logic stamp_enable,
  input wire logic [63:0] cycleStamp,
  input wire logic countersLoad,
  input wire logic [31:0] branchInterval,
  input wire logic [31:0] missInterval,
  input wire logic branchRetire,
  input wire logic branchConditional,
  input wire logic branch_taken_flag,
  input wire logic merged_op_flag,
  input wire logic prediction_info_valid,
  input wire logic prediction_correct,
  input wire addr_type retired_pc,
  input wire addr_type branchTarget,
  input wire addr_type fallThroughPc,
  output logic branchBusy,
  input wire logic missStart,
  input wire slot_type missStartSlot,
  input wire logic missSecondHalf,
  input wire logic missFromInstruction,
  input wire logic missProfilerAccess,
  input wire addr_type missDataAddr,
  input wire addr_type missPc,
  input wire logic missDone,
  input wire slot_type missDoneSlot,
  input wire logic [2:0] missSource,
  input wire logic [7:0] sourceSelect,
  input wire logic [31:0] miss_latency_threshold,
  input wire logic requireBoth,
  output logic missBusy,
  output logic recordValid,
  input wire logic recordReady,
  output record_type recordData,
  output logic [3:0] latency_round_log2,
  output logic [3:0] latency_cap_log2
);

  // ----------------------------------------
  // Record packing
  // ----------------------------------------
  function automatic record_type packRecord(
    input logic [7:0] code,
    input logic [7:0] tag,
    input logic [7:0] flags,
    input logic [31:0] word1,
    input addr_type quad1,
    input addr_type quad2,
    input addr_type stamp
  );
    // Byte 2 always zero
    packRecord = {stamp, quad2, quad1, word1, flags, 8'h00, tag, code};
  endfunction

  function automatic addr_type stampValue(input logic enable, input addr_type raw);
    stampValue = enable ? raw : 64'h0000000000000000;
  endfunction

  // Signed countdown: result sign bit says negative
  function automatic logic [31:0] countDown(input logic [31:0] value);
    countDown = value - 32'h00000001;
  endfunction

  // ----------------------------------------
  // Branch sampling
  // ----------------------------------------
  logic [31:0] branchCounter;
  logic branchPending;
  record_type branchRecord;

  wire [31:0] branchDec = countDown(branchCounter);
  wire branchAccept = branchRetire && !branchPending;
  wire branchFire = branchAccept && branchDec[31];

  // Unconditional transfers are always taken
  wire takenBit = branch_taken_flag || !branchConditional;
  wire correctBit = prediction_info_valid &&
    (prediction_correct || !branchConditional);

  wire [7:0] branchFlags;
  assign branchFlags[3:0] = 4'h0;
  assign branchFlags[`FLAG_MERGED] = merged_op_flag;
  assign branchFlags[`FLAG_PRED_VALID] = prediction_info_valid;
  assign branchFlags[`FLAG_PRED_CORRECT] = correctBit;
  assign branchFlags[`FLAG_TAKEN] = takenBit;

  // Core hands effective addresses; no segment base is added here
  wire addr_type nextPcSel = takenBit ? branchTarget : fallThroughPc;

  wire record_type branchBuilt = packRecord(
    `CODE_BRANCH,
    coreTag,
    branchFlags,
    32'h00000000,
    retired_pc,
    nextPcSel,
    stampValue(stamp_enable, cycleStamp)
  );

  // ----------------------------------------
  // Miss tracking and filtering
  // ----------------------------------------
  logic doneActive;
  logic [31:0] doneLatency;
  addr_type doneAddr;
  addr_type donePc;

  // Walks, table references and own accesses never get a slot
  wire startCounted = missStart && missFromInstruction
    && !missProfilerAccess;

  miss_latency_tracker u_miss_latency_tracker (
    .clock(clock),
    .resetn(resetn),
    .startValid(startCounted),
    .startSlot(missStartSlot),
    .startSecond(missSecondHalf),
    .startAddr(missDataAddr),
    .startPc(missPc),
    .doneValid(missDone),
    .doneSlot(missDoneSlot),
    .doneActive(doneActive),
    .doneLatency(doneLatency),
    .doneAddr(doneAddr),
    .donePc(donePc)
  );

  logic [31:0] missCounter;
  logic missPending;
  record_type missRecord;

  // Low four threshold bits dropped: threshold is in steps of sixteen
  wire [31:0] thresholdRounded = {miss_latency_threshold[31:4], 4'h0};
  wire overThreshold = doneLatency > thresholdRounded;
  wire sourceHit = sourceSelect[missSource];
  wire eligible = requireBoth ? (overThreshold && sourceHit)
    : (overThreshold || sourceHit);

  wire [31:0] missDec = countDown(missCounter);
  // One completion per slot, so a split load counts once
  wire missAccept = missDone && doneActive && eligible && !missPending;
  wire missFire = missAccept && missDec[31];

  wire [7:0] missFlags;
  assign missFlags[3:0] = 4'h0;
  assign missFlags[`FLAG_ADDR_VALID] = 1'b1;
  assign missFlags[7:`FLAG_SRC_LSB] = missSource;

  wire record_type missBuilt = packRecord(
    `CODE_MISS,
    coreTag,
    missFlags,
    doneLatency,
    donePc,
    doneAddr,
    stampValue(stamp_enable, cycleStamp)
  );

  // ----------------------------------------
  // Event counters
  // ----------------------------------------
  logic [31:0] next_branchCounter;
  logic [31:0] next_missCounter;

  always_comb begin
    next_branchCounter = branchCounter;
    if (branchAccept) begin
      next_branchCounter = branchDec[31] ? branchInterval : branchDec;
    end
    if (countersLoad) begin
      next_branchCounter = branchInterval;
    end
  end

  always_comb begin
    next_missCounter = missCounter;
    if (missAccept) begin
      next_missCounter = missDec[31] ? missInterval : missDec;
    end
    if (countersLoad) begin
      next_missCounter = missInterval;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      branchCounter <= `COUNTER_RESET;
      missCounter <= `COUNTER_RESET;
    end else begin
      branchCounter <= next_branchCounter;
      missCounter <= next_missCounter;
    end
  end

  // ----------------------------------------
  // Write arbitration into the FIFO
  // ----------------------------------------
  logic fifoInReady;
  logic fifoOutValid;
  record_type fifoOutData;
  source_sel_type writeSel;

  // Branch first; the miss record waits while a branch record is pending
  assign writeSel = branchPending ? SEL_BRANCH
    : (missPending ? SEL_MISS : SEL_NONE);

  logic fifoInValid;
  record_type fifoInData;

  always_comb begin
    fifoInValid = 1'b0;
    fifoInData = '0;
    case (writeSel)
      SEL_BRANCH: begin
        fifoInValid = 1'b1;
        fifoInData = branchRecord;
      end
      SEL_MISS: begin
        fifoInValid = 1'b1;
        fifoInData = missRecord;
      end
      default: begin
        fifoInValid = 1'b0;
        fifoInData = '0;
      end
    endcase
  end

  wire branchWritten = fifoInReady && writeSel == SEL_BRANCH;
  wire missWritten = fifoInReady && writeSel == SEL_MISS;

  logic next_branchPending;
  logic next_missPending;

  // Clear first, then set, so a new record is never lost
  always_comb begin
    next_branchPending = branchPending;
    if (branchWritten) begin
      next_branchPending = 1'b0;
    end
    if (branchFire) begin
      next_branchPending = 1'b1;
    end
  end

  always_comb begin
    next_missPending = missPending;
    if (missWritten) begin
      next_missPending = 1'b0;
    end
    if (missFire) begin
      next_missPending = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      branchPending <= 1'b0;
      missPending <= 1'b0;
    end else begin
      branchPending <= next_branchPending;
      missPending <= next_missPending;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      branchRecord <= '0;
      missRecord <= '0;
    end else begin
      if (branchFire) begin
        branchRecord <= branchBuilt;
      end
      if (missFire) begin
        missRecord <= missBuilt;
      end
    end
  end

  // Busy flags stall the core while a record is held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      branchBusy <= 1'b0;
      missBusy <= 1'b0;
    end else begin
      branchBusy <= next_branchPending;
      missBusy <= next_missPending;
    end
  end

  // ----------------------------------------
  // Record buffer and output stage
  // ----------------------------------------
  wire fifoOutReady = !recordValid || recordReady;

  record_fifo #(
    .WIDTH(`RECORD_BITS),
    .DEPTH(`RECORD_DEPTH)
  ) u_record_fifo (
    .clock(clock),
    .resetn(resetn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Registered head keeps the writer's data off the FIFO read mux
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recordValid <= 1'b0;
      recordData <= '0;
    end else if (fifoOutReady) begin
      recordValid <= fifoOutValid;
      if (fifoOutValid) begin
        recordData <= fifoOutData;
      end
    end
  end

  // ----------------------------------------
  // Capability report
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latency_round_log2 <= 4'h0;
      latency_cap_log2 <= 4'h0;
    end else begin
      latency_round_log2 <= 4'(`LAT_ROUND_LOG2);
      latency_cap_log2 <= 4'(`LAT_CAP_LOG2);
    end
  end

endmodule

// file: test/sampler_monitor.sv
`timescale 1ns/100ps
module sampler_monitor
  import event_sampler_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] coreTag,
  input wire logic branchRetire,
  input wire logic branchBusy,
  input wire logic recordValid,
  input wire logic recordReady,
  input wire record_type recordData,
  input wire logic [3:0] latency_round_log2,
  input wire logic [3:0] latency_cap_log2
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic [7:0] code = recordData[7:0];
  chk_round_cap: assert property ($past(resetn) |-> latency_round_log2 == 4'h4)
    else $error("rounding capability wrong");
  chk_sat_cap: assert property ($past(resetn) |-> latency_cap_log2 == 4'ha)
    else $error("saturation capability wrong");
  chk_event_code: assert property (recordValid |-> code == 8'h03 || code == 8'h04)
    else $error("record code wrong");
  chk_tag_copy: assert property (recordValid |-> recordData[15:8] == coreTag)
    else $error("core tag not copied");
  chk_reserved_zero: assert property (recordValid |-> recordData[27:16] == 12'h000)
    else $error("reserved bits set");
  chk_branch_rsvd: assert property (recordValid && code == 8'h03 |-> recordData[63:32] == 32'h0)
    else $error("branch reserved word set");
  chk_pred_gate: assert property (recordValid && code == 8'h03 && !recordData[29] |-> !recordData[30])
    else $error("correct flag without valid prediction");
  chk_miss_round: assert property (recordValid && code == 8'h04 |-> recordData[35:32] == 4'h0 && recordData[28])
    else $error("miss latency not rounded");
  chk_miss_cap: assert property (recordValid && code == 8'h04 |-> recordData[63:32] <= 32'h3f0)
    else $error("miss latency above cap");
  chk_busy_cause: assert property ($rose(branchBusy) |-> $past(branchRetire) || $past(branchRetire, 2))
    else $error("branch busy without retire");
  chk_record_hold: assert property (recordValid && !recordReady |=> recordValid && $stable(recordData))
    else $error("record dropped before accept");
endmodule

bind branch_and_cache_miss_event_sampler sampler_monitor u_sampler_monitor (
  .clock(clock), .resetn(resetn), .coreTag(coreTag), .branchRetire(branchRetire),
  .branchBusy(branchBusy), .recordValid(recordValid), .recordReady(recordReady),
  .recordData(recordData), .latency_round_log2(latency_round_log2),
  .latency_cap_log2(latency_cap_log2)
);

// file: test/record_sink.sv
`timescale 1ns/100ps
module record_sink
  import event_sampler_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic hold,
  input wire logic recordValid,
  input wire record_type recordData,
  output logic recordReady
);
  record_type got[$];
  logic [1:0] phase;
  // Ready drops one cycle in four so the output stage sees back-pressure
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'h0;
      recordReady <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      recordReady <= !hold && phase != 2'h2;
      if (recordValid && recordReady) begin
        got.push_back(recordData);
      end
    end
  end
endmodule

// file: test/branch_and_cache_miss_event_sampler_tb.sv
`timescale 1ns/100ps
module branch_and_cache_miss_event_sampler_tb;
  import event_sampler_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, stamp_enable = 1'b0, countersLoad = 1'b0, hold = 1'b0;
  logic branchRetire = 1'b0, branchConditional = 1'b0, branch_taken_flag = 1'b0;
  logic merged_op_flag = 1'b0, prediction_info_valid = 1'b0, prediction_correct = 1'b0;
  logic missStart = 1'b0, missSecondHalf = 1'b0, missFromInstruction = 1'b0;
  logic missProfilerAccess = 1'b0, missDone = 1'b0, requireBoth = 1'b0;
  logic branchBusy, missBusy, recordValid, recordReady;
  logic [7:0] coreTag = 8'h00, sourceSelect = 8'h00;
  logic [2:0] missSource = 3'h0;
  logic [3:0] latency_round_log2, latency_cap_log2;
  logic [4:0] f;
  logic [31:0] branchInterval = 32'h0, missInterval = 32'h0, miss_latency_threshold = 32'h0;
  logic [63:0] cycleStamp = 64'h0;
  addr_type retired_pc = 64'h0, missDataAddr = 64'h0, branchTarget, fallThroughPc, missPc, pc;
  slot_type missStartSlot = 2'h0, missDoneSlot = 2'h0;
  record_type recordData, rec;
  localparam record_type LAT_MASK = ~{192'h0, 32'hffffffff, 32'h0};
  int seed = 43639, err_count = 0, checks_done = 0;
  assign branchTarget = retired_pc + 64'h40;
  assign fallThroughPc = retired_pc + 64'h2;
  assign missPc = {missDataAddr[63:12], 12'h800};
  always #10 clock = ~clock;
  branch_and_cache_miss_event_sampler u_branch_and_cache_miss_event_sampler (.*);
  record_sink u_record_sink (.*);

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_rec(record_type got, record_type exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(logic [31:0] got, int lo, int hi);
    checks_done++;
    if (got[3:0] !== 4'h0 || got < lo || got > hi) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  function automatic logic [63:0] stamp_val();
    return stamp_enable ? cycleStamp : 64'h0;
  endfunction
  function automatic record_type brec(logic [4:0] g, addr_type a);
    logic t;
    t = g[3] | !g[4];
    return {stamp_val(), t ? a + 64'h40 : a + 64'h2, a, 32'h0,
      t, g[1] & (g[0] | !g[4]), g[1], g[2], 4'h0, 8'h00, coreTag, 8'h03};
  endfunction
  function automatic record_type mrec(addr_type a, logic [2:0] src);
    return {stamp_val(), a, a[63:12], 12'h800, 32'h0, src, 1'b1, 4'h0, 8'h00, coreTag, 8'h04};
  endfunction
  task automatic wait_clear(ref logic s);
    int n;
    n = 0;
    @(negedge clock);
    @(negedge clock);
    while (s !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic next_rec;
    int n;
    n = 0;
    while (u_record_sink.got.size() == 0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    rec = u_record_sink.got.size() ? u_record_sink.got.pop_front() : '0;
  endtask
  task automatic chk_none;
    repeat (30) @(negedge clock);
    chk_val(u_record_sink.got.size(), 32'h0);
  endtask
  task automatic load(logic [31:0] bi, logic [31:0] mi);
    @(posedge clock);
    branchInterval <= bi;
    missInterval <= mi;
    countersLoad <= 1'b1;
    @(posedge clock);
    countersLoad <= 1'b0;
  endtask
  task automatic cfg(logic [7:0] sel, logic [31:0] thr, logic both);
    @(posedge clock);
    sourceSelect <= sel;
    miss_latency_threshold <= thr;
    requireBoth <= both;
  endtask
  task automatic retire(logic [4:0] g, addr_type a);
    wait_clear(branchBusy);
    @(posedge clock);
    branchRetire <= 1'b1;
    {branchConditional, branch_taken_flag, merged_op_flag} <= g[4:2];
    {prediction_info_valid, prediction_correct} <= g[1:0];
    retired_pc <= a;
    stamp_enable <= a[8];
    cycleStamp <= ~a;
    @(posedge clock);
    branchRetire <= 1'b0;
  endtask
  // Kind bits: second half, from instruction, profiler access
  task automatic mstart(slot_type s, logic [2:0] k, addr_type a);
    @(posedge clock);
    {missStart, missSecondHalf, missFromInstruction, missProfilerAccess} <= {1'b1, k};
    missStartSlot <= s;
    missDataAddr <= a;
    @(posedge clock);
    missStart <= 1'b0;
  endtask
  task automatic mdone(slot_type s, logic [2:0] src);
    wait_clear(missBusy);
    @(posedge clock);
    missDone <= 1'b1;
    missDoneSlot <= s;
    missSource <= src;
    @(posedge clock);
    missDone <= 1'b0;
  endtask
  task automatic miss(slot_type s, logic [2:0] src, addr_type a, int w);
    mstart(s, 3'h2, a);
    repeat (w) @(posedge clock);
    mdone(s, src);
  endtask
  // Latency is only known to one tick of the shared prescaler
  task automatic mexp(addr_type a, logic [2:0] src, int w);
    int lo, hi;
    lo = (w + 3) / 16 * 16 - 16;
    hi = lo + 32;
    next_rec;
    chk_rec(rec & LAT_MASK, mrec(a, src));
    chk_lat(rec[63:32], lo < 0 ? 0 : (lo > 1008 ? 1008 : lo), hi > 1008 ? 1008 : hi);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    coreTag <= 8'($random(seed));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(negedge clock);
    chk_val(latency_round_log2, 32'h4);
    chk_val(latency_cap_log2, 32'ha);
    load(32'h2, 32'h0);
    retire(5'b11011, 64'h1000);
    retire(5'b10011, 64'h1010);
    chk_none;
    retire(5'b11011, 64'h1100);
    next_rec;
    chk_rec(rec, brec(5'b11011, 64'h1100));
    load(32'h0, 32'h0);
    for (int i = 0; i < 24; i++) begin
      f = (i == 0) ? 5'b00010 : 5'($random(seed));
      pc = {$random(seed), $random(seed)};
      retire(f, pc);
      next_rec;
      chk_rec(rec, brec(f, pc));
    end
    hold <= 1'b1;
    for (int i = 0; i < 10; i++) retire(5'b01100, 64'h2000 + 64'(i * 16));
    repeat (20) @(negedge clock);
    chk_val(branchBusy, 32'h1);
    // A miss record behind a full buffer must hold its busy flag
    cfg(8'h02, 32'hfff0, 1'b0);
    miss(2'h0, 3'h1, 64'he000, 4);
    repeat (4) @(negedge clock);
    chk_val(missBusy, 32'h1);
    hold <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      next_rec;
      chk_rec(rec, brec(5'b01100, 64'h2000 + 64'(i * 16)));
    end
    mexp(64'he000, 3'h1, 4);
    for (int k = 0; k < 8; k++) begin
      cfg(8'h01 << k, 32'hfff0, 1'b0);
      miss(2'(k), 3'(k), 64'h8000 + 64'(k * 8), 4);
      mexp(64'h8000 + 64'(k * 8), 3'(k), 4);
      miss(2'(k), 3'(k + 1), 64'h9000, 4);
      chk_none;
    end
    cfg(8'h00, 32'h40, 1'b0);
    miss(2'h0, 3'h3, 64'ha000, 20);
    chk_none;
    miss(2'h1, 3'h3, 64'ha100, 200);
    mexp(64'ha100, 3'h3, 200);
    cfg(8'h08, 32'h40, 1'b1);
    miss(2'h2, 3'h3, 64'ha200, 20);
    miss(2'h2, 3'h2, 64'ha300, 200);
    chk_none;
    miss(2'h2, 3'h3, 64'ha400, 200);
    mexp(64'ha400, 3'h3, 200);
    cfg(8'hff, 32'hfff0, 1'b0);
    mstart(2'h0, 3'h0, 64'hd000);
    mdone(2'h0, 3'h3);
    chk_none;
    mstart(2'h0, 3'h3, 64'hd100);
    mdone(2'h0, 3'h3);
    chk_none;
    load(32'h0, 32'h1);
    mstart(2'h1, 3'h2, 64'hb040);
    mstart(2'h1, 3'h6, 64'hb000);
    mdone(2'h1, 3'h5);
    chk_none;
    load(32'h0, 32'h0);
    mstart(2'h1, 3'h2, 64'hb080);
    mstart(2'h1, 3'h6, 64'hb038);
    mdone(2'h1, 3'h5);
    mexp(64'hb038, 3'h5, 2);
    mstart(2'h0, 3'h2, 64'hc000);
    repeat (1200) @(posedge clock);
    miss(2'h3, 3'h1, 64'hc100, 60);
    mexp(64'hc100, 3'h1, 60);
    mdone(2'h0, 3'h7);
    mexp(64'hc000, 3'h7, 1300);
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    stop_test;
  end
endmodule
